// [rtl/bst_regs.svh]
// constants of the boundary-scan test access port controller
`ifndef BST_REGS_SVH
`define BST_REGS_SVH
`define BST_IR_W          8
`define BST_BSR_W         18
`define BST_CTL_W         2
`define BST_SYNC_W        21
`define BST_IR_CAPTURE    8'h81
`define BST_IR_RESET      8'hFF
`define BST_CTL_RESET     2'h2
`define BST_RESET_TMS     5
`define BST_OP_EXTEST     7'h00
`define BST_OP_SAMPLE     7'h02
`define BST_OP_INTEST     7'h03
`define BST_OP_HIGHZ      7'h06
`define BST_OP_CLAMP      7'h07
`define BST_OP_RUNT       7'h09
`define BST_OP_SEL_CTL    7'h0A
`endif

// [rtl/bst_pkg.sv]
// types of the boundary-scan test access port controller
package bst_pkg;
    // gray sequence along the usual walk through the sixteen states
    typedef enum logic [3:0] {
        BST_RESET    = 4'h0,
        BST_IDLE     = 4'h1,
        BST_SEL_DR   = 4'h3,
        BST_CAP_DR   = 4'h2,
        BST_SHIFT_DR = 4'h6,
        BST_EXIT1_DR = 4'h7,
        BST_PAUSE_DR = 4'h5,
        BST_EXIT2_DR = 4'h4,
        BST_UPD_DR   = 4'hC,
        BST_SEL_IR   = 4'hD,
        BST_CAP_IR   = 4'hF,
        BST_SHIFT_IR = 4'hE,
        BST_EXIT1_IR = 4'hA,
        BST_PAUSE_IR = 4'hB,
        BST_EXIT2_IR = 4'h9,
        BST_UPD_IR   = 4'h8
    } bst_state_type;

    // data register placed in the scan path
    typedef enum logic [1:0] {
        BST_DR_BYPASS   = 2'h0,
        BST_DR_BOUNDARY = 2'h1,
        BST_DR_CONTROL  = 2'h2
    } bst_dr_type;
endpackage

// [rtl/bst_sync.sv]
// two-flop synchroniser for the test pins
module bst_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_nxt;

    // first stage feeds only the second
    always_comb begin
        meta_nxt = i_async;
        sync_nxt = meta_r;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_r <= '0;
            o_sync <= '0;
        end else begin
            meta_r <= meta_nxt;
            o_sync <= sync_nxt;
        end
    end
endmodule

// [rtl/bst_tap_ctrl.sv]
// test access port controller with instruction and data scan paths
`include "bst_regs.svh"

module bst_tap_ctrl (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset,
    input  wire logic                  i_tck,
    input  wire logic                  i_tms,
    input  wire logic                  i_tdi,
    input  wire logic [`BST_BSR_W-1:0] i_bsr_capture,
    output logic                       o_tdo,
    output logic                       o_tdo_oe,
    output logic                       o_test_mode,
    output logic                       o_run_active,
    output logic [`BST_IR_W-1:0]       o_instr,
    output logic [`BST_CTL_W-1:0]      o_run_op,
    output logic [`BST_BSR_W-1:0]      o_bsr_hold
);
    import bst_pkg::*;

    localparam int ResetCycles = `BST_RESET_TMS;

    logic [`BST_SYNC_W-1:0] sync_s;
    logic                   tck_s;
    logic                   tms_s;
    logic                   tdi_s;
    logic [`BST_BSR_W-1:0]  cap_s;
    logic                   tck_d_r;
    logic                   tck_d_nxt;
    logic                   tck_rise;
    logic                   tck_fall;
    bst_state_type          state_r;
    bst_state_type          state_nxt;
    bst_dr_type             dr_sel;
    logic [`BST_IR_W-1:0]   ir_shift_r;
    logic [`BST_IR_W-1:0]   ir_shift_nxt;
    logic [`BST_BSR_W-1:0]  bsr_shift_r;
    logic [`BST_BSR_W-1:0]  bsr_shift_nxt;
    logic [`BST_CTL_W-1:0]  ctl_shift_r;
    logic [`BST_CTL_W-1:0]  ctl_shift_nxt;
    logic                   byp_r;
    logic                   byp_nxt;
    logic                   tdo_nxt;
    logic                   tdo_oe_nxt;
    logic                   test_mode_nxt;
    logic                   run_active_nxt;
    logic [`BST_IR_W-1:0]   instr_nxt;
    logic [`BST_CTL_W-1:0]  run_op_nxt;
    logic [`BST_BSR_W-1:0]  bsr_hold_nxt;
    logic [2:0]             tms_hi_r;
    logic [2:0]             tms_hi_nxt;

    // pins come from the tester's domain, so all pass two flops
    bst_sync #(
        .WIDTH(`BST_SYNC_W)
    ) u_sync (
        .i_clk  (i_clk),
        .i_reset(i_reset),
        .i_async({i_bsr_capture, i_tdi, i_tms, i_tck}),
        .o_sync (sync_s)
    );

    assign tck_s = sync_s[0];
    assign tms_s = sync_s[1];
    assign tdi_s = sync_s[2];
    assign cap_s = sync_s[`BST_SYNC_W-1:3];

    // tck edges seen on the system clock; tms and tdi share the same delay
    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;

    // standard transition table of the test access port
    function automatic bst_state_type next_state(input bst_state_type st, input logic tms);
        case (st)
            BST_RESET:    next_state = tms ? BST_RESET : BST_IDLE;
            BST_IDLE:     next_state = tms ? BST_SEL_DR : BST_IDLE;
            BST_SEL_DR:   next_state = tms ? BST_SEL_IR : BST_CAP_DR;
            BST_CAP_DR:   next_state = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
            BST_SHIFT_DR: next_state = tms ? BST_EXIT1_DR : BST_SHIFT_DR;
            BST_EXIT1_DR: next_state = tms ? BST_UPD_DR : BST_PAUSE_DR;
            BST_PAUSE_DR: next_state = tms ? BST_EXIT2_DR : BST_PAUSE_DR;
            BST_EXIT2_DR: next_state = tms ? BST_UPD_DR : BST_SHIFT_DR;
            BST_UPD_DR:   next_state = tms ? BST_SEL_DR : BST_IDLE;
            BST_SEL_IR:   next_state = tms ? BST_RESET : BST_CAP_IR;
            BST_CAP_IR:   next_state = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
            BST_SHIFT_IR: next_state = tms ? BST_EXIT1_IR : BST_SHIFT_IR;
            BST_EXIT1_IR: next_state = tms ? BST_UPD_IR : BST_PAUSE_IR;
            BST_PAUSE_IR: next_state = tms ? BST_EXIT2_IR : BST_PAUSE_IR;
            BST_EXIT2_IR: next_state = tms ? BST_UPD_IR : BST_SHIFT_IR;
            BST_UPD_IR:   next_state = tms ? BST_SEL_DR : BST_IDLE;
            default:      next_state = BST_RESET;
        endcase
    endfunction

    // opcode bit 7 is ignored; unknown codes fall back to bypass
    function automatic bst_dr_type dr_select(input logic [`BST_IR_W-1:0] ir);
        case (ir[6:0])
            `BST_OP_EXTEST,
            `BST_OP_SAMPLE,
            `BST_OP_INTEST:  dr_select = BST_DR_BOUNDARY;
            `BST_OP_SEL_CTL: dr_select = BST_DR_CONTROL;
            default:         dr_select = BST_DR_BYPASS;
        endcase
    endfunction

    function automatic logic is_test(input logic [`BST_IR_W-1:0] ir);
        case (ir[6:0])
            `BST_OP_EXTEST,
            `BST_OP_INTEST,
            `BST_OP_HIGHZ,
            `BST_OP_CLAMP,
            `BST_OP_RUNT:    is_test = 1'b1;
            default:         is_test = 1'b0;
        endcase
    endfunction

    assign dr_sel = dr_select(o_instr);

    // controller state advances only on a rising tck
    always_comb begin
        tck_d_nxt = tck_s;
        state_nxt = state_r;
        if (tck_rise) begin
            state_nxt = next_state(state_r, tms_s);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tck_d_r <= 1'b0;
            state_r <= BST_RESET;
        end else begin
            tck_d_r <= tck_d_nxt;
            state_r <= state_nxt;
        end
    end

    // shift stages: capture and shift on rising tck, pause simply holds
    always_comb begin
        ir_shift_nxt  = ir_shift_r;
        bsr_shift_nxt = bsr_shift_r;
        ctl_shift_nxt = ctl_shift_r;
        byp_nxt       = byp_r;
        if (tck_rise) begin
            case (state_r)
                BST_CAP_IR: begin
                    ir_shift_nxt = `BST_IR_CAPTURE;
                end
                BST_SHIFT_IR: begin
                    ir_shift_nxt = {tdi_s, ir_shift_r[`BST_IR_W-1:1]};
                end
                BST_CAP_DR: begin
                    case (dr_sel)
                        BST_DR_BOUNDARY: bsr_shift_nxt = cap_s;
                        BST_DR_CONTROL:  ctl_shift_nxt = ctl_shift_r;
                        default:         byp_nxt = 1'b0;
                    endcase
                end
                BST_SHIFT_DR: begin
                    case (dr_sel)
                        BST_DR_BOUNDARY: bsr_shift_nxt = {tdi_s, bsr_shift_r[`BST_BSR_W-1:1]};
                        BST_DR_CONTROL:  ctl_shift_nxt = {tdi_s, ctl_shift_r[1]};
                        default:         byp_nxt = tdi_s;
                    endcase
                end
                default: begin
                    // pause, exit and the rest keep the stages untouched
                    ir_shift_nxt = ir_shift_r;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ir_shift_r  <= `BST_IR_CAPTURE;
            bsr_shift_r <= '0;
            ctl_shift_r <= `BST_CTL_RESET;
            byp_r       <= 1'b0;
        end else begin
            ir_shift_r  <= ir_shift_nxt;
            bsr_shift_r <= bsr_shift_nxt;
            ctl_shift_r <= ctl_shift_nxt;
            byp_r       <= byp_nxt;
        end
    end

    // everything seen outside moves on falling tck, a half cycle after sampling
    always_comb begin
        tdo_nxt        = o_tdo;
        tdo_oe_nxt     = o_tdo_oe;
        instr_nxt      = o_instr;
        run_op_nxt     = o_run_op;
        bsr_hold_nxt   = o_bsr_hold;
        test_mode_nxt  = o_test_mode;
        run_active_nxt = o_run_active;
        if (tck_fall) begin
            // one path at a time: instruction in shift-ir, else the selected dr
            tdo_oe_nxt = (state_r == BST_SHIFT_IR) || (state_r == BST_SHIFT_DR);
            if (state_r == BST_SHIFT_IR) begin
                tdo_nxt = ir_shift_r[0];
            end else begin
                case (dr_sel)
                    BST_DR_BOUNDARY: tdo_nxt = bsr_shift_r[0];
                    BST_DR_CONTROL:  tdo_nxt = ctl_shift_r[0];
                    default:         tdo_nxt = byp_r;
                endcase
            end
            case (state_r)
                BST_RESET: begin
                    instr_nxt  = `BST_IR_RESET;
                    run_op_nxt = `BST_CTL_RESET;
                end
                BST_UPD_IR: begin
                    instr_nxt = ir_shift_r;
                end
                BST_UPD_DR: begin
                    // bypass has no shadow latch, so it updates nothing
                    if (dr_sel == BST_DR_BOUNDARY) begin
                        bsr_hold_nxt = bsr_shift_r;
                    end else if (dr_sel == BST_DR_CONTROL) begin
                        run_op_nxt = ctl_shift_r;
                    end
                end
                default: begin
                    instr_nxt = o_instr;
                end
            endcase
            test_mode_nxt  = (state_r != BST_RESET) && is_test(instr_nxt);
            run_active_nxt = (state_r == BST_IDLE)
                           && (instr_nxt[6:0] == `BST_OP_RUNT);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tdo        <= 1'b1;
            o_tdo_oe     <= 1'b0;
            o_instr      <= `BST_IR_RESET;
            o_run_op     <= `BST_CTL_RESET;
            o_bsr_hold   <= '0;
            o_test_mode  <= 1'b0;
            o_run_active <= 1'b0;
        end else begin
            o_tdo        <= tdo_nxt;
            o_tdo_oe     <= tdo_oe_nxt;
            o_instr      <= instr_nxt;
            o_run_op     <= run_op_nxt;
            o_bsr_hold   <= bsr_hold_nxt;
            o_test_mode  <= test_mode_nxt;
            o_run_active <= run_active_nxt;
        end
    end

    // helper: consecutive rising edges with tms high, saturating
    always_comb begin
        tms_hi_nxt = tms_hi_r;
        if (tck_rise) begin
            tms_hi_nxt = !tms_s ? 3'h0 : ((tms_hi_r == 3'h7) ? 3'h7 : tms_hi_r + 3'h1);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            tms_hi_r <= 3'h0;
        end else begin
            tms_hi_r <= tms_hi_nxt;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_tms_reset_reach: assert property (
        (tms_hi_r >= ResetCycles) |-> (state_r == BST_RESET))
        else $error("tms high five cycles did not reach reset");
    a_outputs_on_fall: assert property (
        ($changed(o_tdo) || $changed(o_tdo_oe) || $changed(o_instr)) |-> $past(tck_fall))
        else $error("test output moved outside a falling tck");
    a_tdo_enable_shift: assert property (
        (tck_fall && state_r == BST_SHIFT_IR) |=> (o_tdo_oe && o_tdo == $past(ir_shift_r[0])))
        else $error("tdo not enabled with instruction lsb");
    a_tdo_disable_exit: assert property (
        (tck_fall && (state_r == BST_EXIT1_DR || state_r == BST_EXIT1_IR)) |=> !o_tdo_oe)
        else $error("tdo still driven after first exit");
    a_select_leaves: assert property (
        (tck_rise && state_r == BST_SEL_DR) |=> (state_r inside {BST_CAP_DR, BST_SEL_IR}))
        else $error("data scan select did not leave");
    a_ir_capture_value: assert property (
        (tck_rise && state_r == BST_CAP_IR) |=> (ir_shift_r == `BST_IR_CAPTURE))
        else $error("instruction capture value wrong");
    a_bypass_zero: assert property (
        (tck_rise && state_r == BST_CAP_DR && dr_sel == BST_DR_BYPASS) |=> !byp_r)
        else $error("bypass did not capture zero");
    a_pause_keeps_data: assert property (
        (state_r == BST_PAUSE_DR) |=> $stable(bsr_shift_r) && $stable(ctl_shift_r))
        else $error("pause lost shifted data");
    a_reset_loads_ir: assert property (
        (tck_fall && state_r == BST_RESET) |=> (o_instr == `BST_IR_RESET
                                              && o_run_op == `BST_CTL_RESET))
        else $error("reset state did not load bypass and selector");
    a_ir_update: assert property (
        (tck_fall && state_r == BST_UPD_IR) |=> (o_instr == $past(ir_shift_r)))
        else $error("instruction not updated in update state");
    a_run_only_idle: assert property (
        (tck_fall && state_r != BST_IDLE) |=> !o_run_active)
        else $error("run-test active outside idle");

    c_dr_scan: cover property (tck_rise && state_r == BST_SHIFT_DR ##[1:1000]
                               tck_fall && state_r == BST_UPD_DR);
    c_ir_update: cover property (tck_fall && state_r == BST_UPD_IR);
    c_tms_reset: cover property (tms_hi_r == 3'h5);
    c_pause_resume: cover property (tck_rise && state_r == BST_EXIT2_DR && !tms_s);
endmodule

// [verif/bst_tap_master.sv]
// behavioural test-bus master that drives tck, tms and tdi and reads tdo
module bst_tap_master (
    input  wire logic i_clk,
    input  wire logic i_tdo,
    input  wire logic i_tdo_oe,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi
);
    timeunit 1ns;
    timeprecision 100ps;

    // tck stands low between frames; tms idles high like the pin pull-up
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b1;
    end

    // step a few system clocks, landing just after the rising edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // one 800 ns tck cycle; tms and tdi change at the fall, held over the rise
    task automatic tick(input logic tms, input logic tdi, output logic tdo, output logic oe);
        o_tms = tms;
        o_tdi = tdi;
        wait_clk(4);
        // tdo is read late in the low half, where the last fall has settled
        tdo   = i_tdo;
        oe    = i_tdo_oe;
        o_tck = 1'b1;
        wait_clk(4);
        o_tck = 1'b0;
    endtask

    // scan from idle back to idle; pause_at above zero parks in pause there
    task automatic scan(input logic is_ir, input int n, input logic [17:0] din,
                        input int pause_at, output logic [17:0] dout, output logic oe_ok);
        logic t;
        logic o;
        dout  = '0;
        oe_ok = 1'b1;
        tick(1'b1, 1'b1, t, o);
        if (is_ir) begin
            tick(1'b1, 1'b1, t, o);
        end
        tick(1'b0, 1'b1, t, o);
        tick(1'b0, 1'b1, t, o);
        for (int i = 0; i < n; i++) begin
            // last bit or pause point leaves shift on its own rise
            tick((i == n - 1) || (i == pause_at - 1), din[i], dout[i], o);
            oe_ok = oe_ok & (o === 1'b1);
            if (i == pause_at - 1) begin
                tick(1'b0, 1'b1, t, o);
                oe_ok = oe_ok & (o === 1'b0);
                tick(1'b0, 1'b1, t, o);
                tick(1'b0, 1'b1, t, o);
                tick(1'b1, 1'b1, t, o);
                tick(1'b0, 1'b1, t, o);
            end
        end
        tick(1'b1, 1'b1, t, o);
        oe_ok = oe_ok & (o === 1'b0);
        tick(1'b0, 1'b1, t, o);
    endtask
endmodule

// [verif/bst_tap_ctrl_tb.sv]
// self-checking bench for the test access port controller
`include "bst_regs.svh"

module bst_tap_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  i_clk;
    logic                  i_reset;
    logic                  tck;
    logic                  tms;
    logic                  tdi;
    logic [`BST_BSR_W-1:0] bsr_cap;
    logic                  tdo;
    logic                  tdo_oe;
    logic                  test_mode;
    logic                  run_active;
    logic [`BST_IR_W-1:0]  instr;
    logic [`BST_CTL_W-1:0] run_op;
    logic [`BST_BSR_W-1:0] bsr_hold;
    logic [17:0]           d;
    logic                  ok;
    logic                  t;
    logic                  o;
    int                    error_cnt = 0;
    int                    cmp_count = 0;

    // 10 MHz system clock
    always #50 i_clk = ~i_clk;

    bst_tap_ctrl dut (
        .i_clk         (i_clk),
        .i_reset       (i_reset),
        .i_tck         (tck),
        .i_tms         (tms),
        .i_tdi         (tdi),
        .i_bsr_capture (bsr_cap),
        .o_tdo         (tdo),
        .o_tdo_oe      (tdo_oe),
        .o_test_mode   (test_mode),
        .o_run_active  (run_active),
        .o_instr       (instr),
        .o_run_op      (run_op),
        .o_bsr_hold    (bsr_hold)
    );

    bst_tap_master m (
        .i_clk    (i_clk),
        .i_tdo    (tdo),
        .i_tdo_oe (tdo_oe),
        .o_tck    (tck),
        .o_tms    (tms),
        .o_tdi    (tdi)
    );

    // case equality so an unknown never passes
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // load an instruction; the captured status comes back on tdo
    task automatic load_ir(input logic [7:0] code);
        m.scan(1'b1, `BST_IR_W, {10'h000, code}, 0, d, ok);
    endtask

    task automatic t_reset_values();
        check("instr", instr, `BST_IR_RESET);
        check("run_op", run_op, `BST_CTL_RESET);
        check("tdo_oe", tdo_oe, 1'b0);
        check("test_mode", test_mode, 1'b0);
        check("run_active", run_active, 1'b0);
        m.tick(1'b0, 1'b1, t, o);
        $display("test reset_values done");
    endtask

    task automatic t_ir_capture();
        load_ir({1'b0, `BST_OP_EXTEST});
        check("ir_capture", d[7:0], `BST_IR_CAPTURE);
        check("ir_oe", ok, 1'b1);
        check("instr", instr, 8'h00);
        check("test_mode", test_mode, 1'b1);
        $display("test ir_capture done");
    endtask

    task automatic t_boundary();
        bsr_cap = 18'h2A5C3;
        m.scan(1'b0, `BST_BSR_W, 18'h1F0E1, 0, d, ok);
        check("bsr_out", d, 18'h2A5C3);
        check("bsr_oe", ok, 1'b1);
        check("bsr_hold", bsr_hold, 18'h1F0E1);
        $display("test boundary done");
    endtask

    // scan split by a pause; a recapture would disturb the shifted-out word
    task automatic t_pause();
        bsr_cap = 18'h0F00F;
        m.scan(1'b0, `BST_BSR_W, 18'h0C3A5, 9, d, ok);
        check("pause_out", d, 18'h0F00F);
        check("pause_oe", ok, 1'b1);
        check("pause_hold", bsr_hold, 18'h0C3A5);
        $display("test pause done");
    endtask

    // a 1-bit path shows the captured zero, then tdi one cycle later
    task automatic t_bypass();
        load_ir({1'b1, 7'h01});
        m.scan(1'b0, 2, 18'h00003, 0, d, ok);
        check("bypass_out", d[1:0], 2'b10);
        check("bypass_hold", bsr_hold, 18'h0C3A5);
        check("test_mode", test_mode, 1'b0);
        $display("test bypass done");
    endtask

    // capture leaves the selector alone, so its reset value shifts out
    task automatic t_selector();
        load_ir({1'b0, `BST_OP_SEL_CTL});
        m.scan(1'b0, `BST_CTL_W, 18'h00001, 0, d, ok);
        check("sel_out", d[1:0], `BST_CTL_RESET);
        check("run_op", run_op, 2'b01);
        $display("test selector done");
    endtask

    // sample stays in normal mode on the boundary path; clamp and highz are test modes
    task automatic t_modes();
        load_ir({1'b1, `BST_OP_SAMPLE});
        check("sample_mode", test_mode, 1'b0);
        bsr_cap = 18'h15A3C;
        m.scan(1'b0, `BST_BSR_W, 18'h3C0FF, 0, d, ok);
        check("sample_out", d, 18'h15A3C);
        check("sample_hold", bsr_hold, 18'h3C0FF);
        load_ir({1'b0, `BST_OP_CLAMP});
        check("clamp_mode", test_mode, 1'b1);
        load_ir({1'b0, `BST_OP_HIGHZ});
        m.scan(1'b0, 2, 18'h00001, 0, d, ok);
        check("highz_out", d[1:0], 2'b10);
        check("highz_mode", test_mode, 1'b1);
        $display("test modes done");
    endtask

    // run-test runs only in idle, then tms high resets from shift-ir
    task automatic t_runt_and_reset();
        load_ir({1'b0, `BST_OP_RUNT});
        // the idle fall lands as the scan returns; let it pass the synchroniser
        m.wait_clk(5);
        check("run_idle", run_active, 1'b1);
        m.tick(1'b1, 1'b1, t, o);
        m.wait_clk(5);
        check("run_sel", run_active, 1'b0);
        m.tick(1'b1, 1'b1, t, o);
        m.tick(1'b0, 1'b1, t, o);
        m.tick(1'b0, 1'b1, t, o);
        repeat (`BST_RESET_TMS) m.tick(1'b1, 1'b1, t, o);
        m.wait_clk(5);
        check("rst_instr", instr, `BST_IR_RESET);
        check("rst_run_op", run_op, `BST_CTL_RESET);
        check("rst_mode", test_mode, 1'b0);
        check("rst_oe", tdo_oe, 1'b0);
        $display("test runt_and_reset done");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // whole run is a few hundred tck cycles; 2 ms leaves ample margin
    initial begin
        #2000000;
        error_cnt++;
        $display("watchdog expired");
        close_out();
    end

    // main sequence
    initial begin
        i_clk   = 1'b0;
        i_reset = 1'b1;
        bsr_cap = '0;
        repeat (20) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        m.wait_clk(3);
        t_reset_values();
        t_ir_capture();
        t_boundary();
        t_pause();
        t_bypass();
        t_selector();
        t_modes();
        t_runt_and_reset();
        close_out();
    end
endmodule
